// >>> rtl/eepc_pkg.sv
// Constants and types for the array program/erase controller
package eepc_pkg;
  // Array window in the processor space
  localparam logic [15:0] ARR_BASE = 16'h0600;
  localparam logic [15:0] ARR_LAST = 16'h07FF;
  localparam logic [15:0] SEC_FIRST = 16'h06F0;
  localparam logic [15:0] SEC_LAST = 16'h06FF;
  localparam int ARR_BYTES = 512;
  localparam int BLOCK_BYTES = 128;
  // Control and configuration registers
  localparam logic [15:0] CTRL_OFS = 16'h0040;
  localparam logic [15:0] ACR_OFS = 16'h0041;
  localparam logic [15:0] DIVH_OFS = 16'h0042;
  localparam logic [15:0] DIVL_OFS = 16'h0043;
  // Non-volatile configuration bytes
  localparam logic [15:0] CFG_NV_OFS = 16'h0044;
  localparam logic [15:0] DIVH_NV_OFS = 16'h0045;
  localparam logic [15:0] DIVL_NV_OFS = 16'h0046;
  // Storage indices: array first, then the three configuration bytes
  localparam logic [9:0] IDX_CFG = 10'h200;
  localparam logic [9:0] IDX_DIVH = 10'h201;
  localparam logic [9:0] IDX_DIVL = 10'h202;
  localparam int MEM_WORDS = 515;
  localparam logic [9:0] SEC_IDX_FIRST = 10'(SEC_FIRST - ARR_BASE);
  localparam logic [9:0] SEC_IDX_LAST = 10'(SEC_LAST - ARR_BASE);
  // Field positions
  localparam int CTRL_PGM = 0;
  localparam int CTRL_AUTO = 2;
  localparam int CTRL_LAT = 3;
  localparam int CTRL_OPLO = 4;
  localparam int CTRL_OPHI = 5;
  localparam int ACR_ARM = 4;
  localparam int DIVH_SECD = 7;
  // Values after reset and as delivered
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ACR_RST = 8'hFF;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [7:0] ERASED = 8'hFF;
  // Timebase and automatic termination, in 35 us ticks
  localparam int TICK_US = 35;
  localparam int CLK_MHZ = 125;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [7:0] PGM_TICKS = 8'h0A;
  localparam logic [7:0] BYTE_TICKS = 8'h0A;
  localparam logic [7:0] BLOCK_TICKS = 8'h0A;
  localparam logic [7:0] BULK_TICKS = 8'h0A;

  typedef enum logic [1:0] {
    EEPC_OP_PGM,
    EEPC_OP_BYTE,
    EEPC_OP_BLOCK,
    EEPC_OP_BULK
  } eepc_op_t;

  typedef enum logic {
    EEPC_LOAD,
    EEPC_RUN
  } eepc_phase_t;
endpackage

// >>> rtl/eepc_timebase.sv
// Reference divider giving one tick per divisor reference events
module eepc_timebase (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic crystal_ref_clock,
  input wire logic timebase_ref_select,
  input wire logic [10:0] divisor,
  input wire logic run,
  output logic tick
);
  typedef struct packed {
    logic [1:0] xs;
    logic [1:0] ss;
    logic xprev;
    logic [10:0] cnt;
    logic tick;
  } eepc_tb_st_t;

  eepc_tb_st_t st;
  eepc_tb_st_t next_st;
  logic ev;
  logic [10:0] cnt_inc;

  always_comb begin
    next_st = st;
    next_st.xs = {st.xs[0], crystal_ref_clock};
    next_st.ss = {st.ss[0], timebase_ref_select};
    next_st.xprev = st.xs[1];
    next_st.tick = 1'b0;
    // Crystal edges only count once synchronised; bus clock counts every edge
    ev = st.ss[1] ? (st.xs[1] & ~st.xprev) : 1'b1;
    cnt_inc = st.cnt + 11'h001;
    if (!run) begin
      next_st.cnt = 11'h000;
    end else if (ev) begin
      if (cnt_inc >= divisor) begin
        next_st.cnt = 11'h000;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = cnt_inc;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

// >>> rtl/eepc_array.sv
// Non-volatile storage: 512 array bytes plus three configuration bytes
module eepc_array (
  input wire logic mclk,
  input wire logic [9:0] rd_idx,
  output logic [7:0] rd_data,
  input wire logic go,
  input wire eepc_pkg::eepc_op_t op,
  input wire logic [9:0] idx,
  input wire logic [7:0] data,
  output logic [7:0] cfg_nv,
  output logic [7:0] divh_nv,
  output logic [7:0] divl_nv
);
  logic [7:0] mem [0:eepc_pkg::MEM_WORDS-1];

  // Contents survive reset, so only the delivered state is preset
  initial begin
    for (int i = 0; i < eepc_pkg::MEM_WORDS; i++) begin
      mem[i] = eepc_pkg::ERASED;
    end
  end

  always_ff @(posedge mclk) begin
    if (go) begin
      case (op)
        eepc_pkg::EEPC_OP_PGM: begin
          mem[idx] <= mem[idx] & data;
        end
        eepc_pkg::EEPC_OP_BYTE: begin
          mem[idx] <= eepc_pkg::ERASED;
        end
        eepc_pkg::EEPC_OP_BLOCK: begin
          for (int i = 0; i < eepc_pkg::BLOCK_BYTES; i++) begin
            mem[{1'b0, idx[8:7], i[6:0]}] <= eepc_pkg::ERASED;
          end
        end
        eepc_pkg::EEPC_OP_BULK: begin
          for (int i = 0; i < eepc_pkg::ARR_BYTES; i++) begin
            mem[{1'b0, i[8:0]}] <= eepc_pkg::ERASED;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign rd_data = mem[rd_idx];
  assign cfg_nv = mem[eepc_pkg::IDX_CFG];
  assign divh_nv = mem[eepc_pkg::IDX_DIVH];
  assign divl_nv = mem[eepc_pkg::IDX_DIVL];
endmodule

// >>> rtl/eepc_ctrl.sv
// Program/erase controller for the 512-byte non-volatile array
// Operation
// - Array occupies 512 bytes from 0x0600 to 0x07FF.
// - Reset copies configuration and divider bytes into volatile registers.
// - 35 us timebase from crystal or bus clock, chosen by select input.
// - Divisor is reference Hz times 35e-6 plus 0.5, truncated.
// - Armed security blocks program/erase of 0x06F0..0x06FF; reads stay normal.
// - Armed security freezes the configuration byte against program/erase.
// - Armed security forbids block and bulk erase; byte operations remain.
// - Four 128-byte blocks, each with a protect bit blocking operations.
// - Block protection refreshes at reset or on reading the configuration byte with latch clear.
// - Divider lock bit at zero freezes divider registers and their bytes.
// - Erased cells read one; delivered array holds 0xFF everywhere.
// - Programming only clears bits, one to eight within a byte.
// - Erase sets bits, from one byte up to the whole array.
// - Automatic mode ends the cycle by timer and clears program-enable.
// - Only unprotected bytes and configuration bytes may be operated on.
// - Program-enable sets only with latch set and a valid captured address.
// - Clearing enable and latch together clears only enable.
// - Latched writes capture address and data; latched reads return capture.
// - Mode bits select byte program, byte, block or bulk erase.
module eepc_ctrl #(
  parameter logic [7:0] PGM_TICKS = eepc_pkg::PGM_TICKS,
  parameter logic [7:0] BYTE_TICKS = eepc_pkg::BYTE_TICKS,
  parameter logic [7:0] BLOCK_TICKS = eepc_pkg::BLOCK_TICKS,
  parameter logic [7:0] BULK_TICKS = eepc_pkg::BULK_TICKS
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic crystal_ref_clock,
  input wire logic timebase_ref_select,
  output logic hv_apply_active
);
  typedef struct packed {
    eepc_pkg::eepc_phase_t phase;
    logic [7:0] ctrl;
    logic [7:0] acr;
    logic [7:0] divh;
    logic [7:0] divl;
    logic [9:0] cap_idx;
    logic [7:0] cap_data;
    logic cap_valid;
    logic [7:0] ticks;
    logic [7:0] rdata;
    logic hv;
  } eepc_st_t;

  eepc_st_t st;
  eepc_st_t next_st;
  logic go;
  logic done;
  logic grant_ok;
  logic armed;
  logic secd;
  logic pgm;
  logic lat;
  logic tick;
  logic [10:0] dec;
  logic [7:0] arr_rd;
  logic [7:0] cfg_nv;
  logic [7:0] divh_nv;
  logic [7:0] divl_nv;
  eepc_pkg::eepc_op_t op;

  // Bit 10 marks a storage address, bits 9:0 give its index
  function automatic logic [10:0] eepc_decode(input logic [15:0] a);
    if (a >= eepc_pkg::ARR_BASE && a <= eepc_pkg::ARR_LAST) begin
      return {2'b10, a[8:0]};
    end
    case (a)
      eepc_pkg::CFG_NV_OFS: return {1'b1, eepc_pkg::IDX_CFG};
      eepc_pkg::DIVH_NV_OFS: return {1'b1, eepc_pkg::IDX_DIVH};
      eepc_pkg::DIVL_NV_OFS: return {1'b1, eepc_pkg::IDX_DIVL};
      default: return 11'h000;
    endcase
  endfunction

  function automatic logic eepc_allowed(input logic [9:0] i,
      input eepc_pkg::eepc_op_t o, input logic [7:0] acr, input logic sd);
    logic arm;
    logic ok;
    arm = ~acr[eepc_pkg::ACR_ARM];
    ok = 1'b1;
    if (i[9]) begin
      // Configuration bytes behave as single bytes only
      if (o == eepc_pkg::EEPC_OP_BLOCK || o == eepc_pkg::EEPC_OP_BULK) begin
        ok = 1'b0;
      end
      if (i == eepc_pkg::IDX_CFG && arm) begin
        ok = 1'b0;
      end
      if (i != eepc_pkg::IDX_CFG && !sd) begin
        ok = 1'b0;
      end
    end else begin
      if (acr[i[8:7]]) begin
        ok = 1'b0;
      end
      // Bulk would touch every block, so any protected block refuses it
      if (o == eepc_pkg::EEPC_OP_BULK && |acr[3:0]) begin
        ok = 1'b0;
      end
      if (arm && (o == eepc_pkg::EEPC_OP_BLOCK ||
          o == eepc_pkg::EEPC_OP_BULK)) begin
        ok = 1'b0;
      end
      if (arm && i >= eepc_pkg::SEC_IDX_FIRST &&
          i <= eepc_pkg::SEC_IDX_LAST) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [7:0] eepc_target(input eepc_pkg::eepc_op_t o);
    case (o)
      eepc_pkg::EEPC_OP_PGM: return PGM_TICKS;
      eepc_pkg::EEPC_OP_BYTE: return BYTE_TICKS;
      eepc_pkg::EEPC_OP_BLOCK: return BLOCK_TICKS;
      default: return BULK_TICKS;
    endcase
  endfunction

  eepc_timebase u_timebase (
    .mclk(mclk),
    .rst_b(rst_b),
    .crystal_ref_clock(crystal_ref_clock),
    .timebase_ref_select(timebase_ref_select),
    .divisor({st.divh[2:0], st.divl}),
    .run(pgm & st.ctrl[eepc_pkg::CTRL_AUTO]),
    .tick(tick)
  );

  eepc_array u_array (
    .mclk(mclk),
    .rd_idx(dec[9:0]),
    .rd_data(arr_rd),
    .go(go),
    .op(op),
    .idx(st.cap_idx),
    .data(st.cap_data),
    .cfg_nv(cfg_nv),
    .divh_nv(divh_nv),
    .divl_nv(divl_nv)
  );

  always_comb begin
    next_st = st;
    go = 1'b0;
    pgm = st.ctrl[eepc_pkg::CTRL_PGM];
    lat = st.ctrl[eepc_pkg::CTRL_LAT];
    armed = ~st.acr[eepc_pkg::ACR_ARM];
    secd = st.divh[eepc_pkg::DIVH_SECD];
    op = eepc_pkg::eepc_op_t'(
        st.ctrl[eepc_pkg::CTRL_OPHI:eepc_pkg::CTRL_OPLO]);
    dec = eepc_decode(addr);
    grant_ok = eepc_allowed(st.cap_idx, op, st.acr, secd);
    done = pgm && st.ctrl[eepc_pkg::CTRL_AUTO] &&
        st.ticks >= eepc_target(op);
    next_st.rdata = 8'h00;
    if (st.phase == eepc_pkg::EEPC_LOAD) begin
      next_st.acr = cfg_nv;
      next_st.divh = divh_nv;
      next_st.divl = divl_nv;
      next_st.phase = eepc_pkg::EEPC_RUN;
    end else begin
      if (pgm && st.ctrl[eepc_pkg::CTRL_AUTO] && tick) begin
        next_st.ticks = 8'(st.ticks + 8'h01);
      end
      if (done) begin
        next_st.ctrl[eepc_pkg::CTRL_PGM] = 1'b0;
        next_st.ticks = 8'h00;
        go = 1'b1;
      end
      if (wr && addr == eepc_pkg::CTRL_OFS) begin
        if (pgm) begin
          // Latch and mode stay frozen while high voltage is applied
          if (!wdata[eepc_pkg::CTRL_PGM] && !done) begin
            next_st.ctrl[eepc_pkg::CTRL_PGM] = 1'b0;
            next_st.ticks = 8'h00;
            go = 1'b1;
          end
        end else begin
          next_st.ctrl = wdata;
          next_st.ctrl[eepc_pkg::CTRL_PGM] = wdata[eepc_pkg::CTRL_PGM] &&
              lat && st.cap_valid && grant_ok;
          if (!wdata[eepc_pkg::CTRL_LAT]) begin
            next_st.cap_valid = 1'b0;
          end
        end
      end
      if (wr && dec[10] && lat && !pgm) begin
        next_st.cap_idx = dec[9:0];
        next_st.cap_data = wdata;
        next_st.cap_valid = 1'b1;
      end
      // Divider is frozen while latched or once its lock is armed
      if (wr && !lat && secd) begin
        if (addr == eepc_pkg::DIVH_OFS) begin
          next_st.divh = wdata;
        end
        if (addr == eepc_pkg::DIVL_OFS) begin
          next_st.divl = wdata;
        end
      end
      if (rd) begin
        case (addr)
          eepc_pkg::CTRL_OFS: next_st.rdata = st.ctrl;
          eepc_pkg::ACR_OFS: next_st.rdata = st.acr;
          eepc_pkg::DIVH_OFS: next_st.rdata = st.divh;
          eepc_pkg::DIVL_OFS: next_st.rdata = st.divl;
          default: begin
            if (dec[10] && lat) begin
              next_st.rdata = st.cap_data;
              if (!pgm) begin
                next_st.cap_idx = dec[9:0];
                next_st.cap_valid = 1'b1;
              end
            end else if (dec[10]) begin
              next_st.rdata = arr_rd;
            end
          end
        endcase
        if (addr == eepc_pkg::CFG_NV_OFS && !lat) begin
          next_st.acr[3:0] = cfg_nv[3:0];
        end
      end
    end
    next_st.hv = next_st.ctrl[eepc_pkg::CTRL_PGM];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{phase: eepc_pkg::EEPC_LOAD, ctrl: eepc_pkg::CTRL_RST,
          acr: eepc_pkg::ACR_RST, divh: eepc_pkg::DIV_RST,
          divl: eepc_pkg::DIV_RST, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign hv_apply_active = st.hv;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_grant;
    !st.ctrl[eepc_pkg::CTRL_PGM] ##1 st.ctrl[eepc_pkg::CTRL_PGM];
  endsequence

  sequence s_clear_both;
    st.ctrl[eepc_pkg::CTRL_PGM] && wr && addr == eepc_pkg::CTRL_OFS &&
        !wdata[eepc_pkg::CTRL_PGM] && !wdata[eepc_pkg::CTRL_LAT];
  endsequence

  a_grant_needs_latch: assert property (
    s_grant |-> $past(st.ctrl[eepc_pkg::CTRL_LAT] && st.cap_valid))
    else $error("enable set without latch and valid capture");

  a_secure_range_kept: assert property (
    s_grant ##0 armed |-> !(st.cap_idx >= eepc_pkg::SEC_IDX_FIRST &&
        st.cap_idx <= eepc_pkg::SEC_IDX_LAST && !st.cap_idx[9]))
    else $error("secured range operation granted");

  a_armed_byte_only: assert property (
    s_grant ##0 armed |-> !st.ctrl[eepc_pkg::CTRL_OPHI] || st.cap_idx[9])
    else $error("block or bulk erase granted while armed");

  a_block_protect: assert property (
    s_grant |-> st.cap_idx[9] || !st.acr[st.cap_idx[8:7]])
    else $error("operation granted in protected block");

  a_clear_keeps_latch: assert property (
    s_clear_both |=> !st.ctrl[eepc_pkg::CTRL_PGM] &&
        st.ctrl[eepc_pkg::CTRL_LAT] && hv_apply_active == 1'b0)
    else $error("latch cleared together with enable");

  a_auto_ends: assert property (
    done |=> !st.ctrl[eepc_pkg::CTRL_PGM] && st.ticks == 8'h00)
    else $error("automatic termination did not clear enable");

  a_latched_read: assert property (
    rd && dec[10] && st.ctrl[eepc_pkg::CTRL_LAT] && addr != 16'h0000
    |=> rdata == $past(st.cap_data))
    else $error("latched read did not return captured data");

  a_divider_lock: assert property (
    !secd && wr && addr == eepc_pkg::DIVL_OFS |=> $stable(st.divl))
    else $error("divider changed while locked");

  a_arm_sticky: assert property (
    st.phase == eepc_pkg::EEPC_RUN && armed |=> armed)
    else $error("security disarmed after arming");

  a_reset_load: assert property (
    // Only the load edge itself counts; reset holds the phase for longer
    st.phase == eepc_pkg::EEPC_LOAD ##1 st.phase == eepc_pkg::EEPC_RUN
    |-> st.acr == $past(cfg_nv) &&
        st.divh == $past(divh_nv) && st.divl == $past(divl_nv))
    else $error("configuration not loaded after reset");
endmodule

// >>> bench/eepc_cpu_model.sv
// Bus master model standing in for the processor core
module eepc_cpu_model (
  input wire logic mclk,
  input wire logic [7:0] rdata,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One-cycle write; bus shows inverted junk once released
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule

// >>> bench/eepc_ctrl_tb_top.sv
// Self-checking bench for the array program/erase controller
module eepc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CR = eepc_pkg::CTRL_OFS;
  localparam logic [15:0] AC = eepc_pkg::ACR_OFS;
  localparam logic [15:0] DH = eepc_pkg::DIVH_OFS;
  localparam logic [15:0] DL = eepc_pkg::DIVL_OFS;
  localparam logic [15:0] CF = eepc_pkg::CFG_NV_OFS;
  localparam logic [15:0] HN = eepc_pkg::DIVH_NV_OFS;
  localparam logic [15:0] LN = eepc_pkg::DIVL_NV_OFS;
  logic mclk;
  logic rst_b;
  logic xclk;
  logic xsel;
  int hv_cycles;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic hv;
  int mismatches;
  int tests_run;

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Crystal runs free, unrelated to the bus clock
  initial begin
    xclk = 1'b0;
    forever #21 xclk = ~xclk;
  end

  eepc_cpu_model cpu (
    .mclk(mclk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd)
  );
  // Short tick targets keep each cycle to a handful of clocks
  eepc_ctrl #(
    .PGM_TICKS(8'h02), .BYTE_TICKS(8'h02),
    .BLOCK_TICKS(8'h02), .BULK_TICKS(8'h02)
  ) DUT (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .crystal_ref_clock(xclk),
    .timebase_ref_select(xsel), .hv_apply_active(hv)
  );

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd_reg(a, d);
    chk($sformatf("read %h", a), e, d);
  endtask

  task automatic hv_chk(input string n, input logic e);
    @(posedge mclk);
    #1;
    chk(n, {7'h00, e}, {7'h00, hv});
  endtask

  // Latch, capture, request auto cycle, wait for self-clear
  task automatic op(input logic [1:0] m, input logic [15:0] a,
                    input logic [7:0] d, input logic ok);
    logic seen;
    seen = 1'b0;
    hv_cycles = 0;
    cpu.wr_reg(CR, {2'b00, m, 4'h8});
    cpu.wr_reg(a, d);
    cpu.wr_reg(CR, {2'b00, m, 4'hD});
    for (int i = 0; i < 600; i++) begin
      @(posedge mclk);
      #1;
      if (hv === 1'b1) begin
        seen = 1'b1;
        hv_cycles++;
      end else if (seen || i >= 6) begin
        break;
      end
    end
    chk($sformatf("enable at %h", a), {7'h00, ok}, {7'h00, seen});
    cpu.wr_reg(CR, 8'h00);
  endtask

  // Enable stays up for two whole ticks plus a few cycles of latency
  task automatic span_chk(input string n, input int lo, input int hi);
    chk(n, 8'h01, {7'h00, hv_cycles >= lo && hv_cycles <= hi});
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    rst_b = 1'b0;
    xsel = 1'b0;
    mismatches = 0;
    tests_run = 0;
    hv_cycles = 0;
    do_reset();
    rdc(AC, 8'hFF);
    rdc(DH, 8'hFF);
    rdc(DL, 8'hFF);
    rdc(16'h0600, 8'hFF);
    rdc(16'h07FF, 8'hFF);
    rdc(16'h0800, 8'h00);
    rdc(16'h05FF, 8'h00);
    done("reset");
    // Divisor of two reference events per tick
    cpu.wr_reg(DH, 8'h80);
    cpu.wr_reg(DL, 8'h02);
    rdc(DH, 8'h80);
    rdc(DL, 8'h02);
    cpu.wr_reg(CR, 8'h05);
    hv_chk("enable without latch", 1'b0);
    cpu.wr_reg(CR, 8'h08);
    cpu.wr_reg(16'h0800, 8'h00);
    cpu.wr_reg(CR, 8'h0D);
    hv_chk("enable without capture", 1'b0);
    cpu.wr_reg(CR, 8'h00);
    done("enable gating");
    op(2'b00, 16'h0612, 8'hFE, 1'b0);
    rdc(16'h0612, 8'hFF);
    op(2'b00, CF, 8'hF0, 1'b1);
    span_chk("bus tick span", 4, 8);
    rdc(AC, 8'hFF);
    rdc(CF, 8'hF0);
    rdc(AC, 8'hF0);
    done("config");
    op(2'b00, 16'h0612, 8'hFE, 1'b1);
    rdc(16'h0612, 8'hFE);
    op(2'b00, 16'h0612, 8'hFD, 1'b1);
    rdc(16'h0612, 8'hFC);
    op(2'b01, 16'h0612, 8'h00, 1'b1);
    rdc(16'h0612, 8'hFF);
    done("byte");
    op(2'b00, 16'h0700, 8'h00, 1'b1);
    op(2'b00, 16'h077F, 8'h0F, 1'b1);
    op(2'b00, 16'h0780, 8'h00, 1'b1);
    op(2'b10, 16'h0710, 8'h00, 1'b1);
    rdc(16'h0700, 8'hFF);
    rdc(16'h077F, 8'hFF);
    rdc(16'h0780, 8'h00);
    op(2'b11, 16'h0600, 8'h00, 1'b1);
    rdc(16'h0780, 8'hFF);
    done("block and bulk");
    // Manual cycle: no auto, software ends it
    cpu.wr_reg(CR, 8'h08);
    cpu.wr_reg(16'h0601, 8'h7F);
    cpu.wr_reg(CR, 8'h09);
    repeat (20) @(posedge mclk);
    hv_chk("manual cycle holds", 1'b1);
    cpu.wr_reg(CR, 8'h00);
    hv_chk("manual clear", 1'b0);
    rdc(CR, 8'h08);
    cpu.wr_reg(CR, 8'h00);
    rdc(CR, 8'h00);
    rdc(16'h0601, 8'h7F);
    done("manual clear");
    cpu.wr_reg(CR, 8'h08);
    cpu.wr_reg(16'h0650, 8'h12);
    cpu.wr_reg(16'h0651, 8'h34);
    rdc(16'h0650, 8'h34);
    cpu.wr_reg(CR, 8'h00);
    rdc(16'h0650, 8'hFF);
    done("capture");
    op(2'b00, 16'h06F5, 8'hAA, 1'b1);
    op(2'b00, LN, 8'h02, 1'b1);
    op(2'b00, HN, 8'h00, 1'b1);
    op(2'b00, CF, 8'hEF, 1'b1);
    rdc(CF, 8'hE0);
    do_reset();
    rdc(AC, 8'hE0);
    rdc(DH, 8'h00);
    rdc(DL, 8'h02);
    cpu.wr_reg(DH, 8'h80);
    rdc(DH, 8'h00);
    cpu.wr_reg(DL, 8'h07);
    rdc(DL, 8'h02);
    op(2'b00, 16'h06F5, 8'h00, 1'b0);
    rdc(16'h06F5, 8'hAA);
    op(2'b00, CF, 8'h00, 1'b0);
    rdc(CF, 8'hE0);
    op(2'b00, LN, 8'h00, 1'b0);
    op(2'b00, 16'h0700, 8'h55, 1'b1);
    op(2'b10, 16'h0710, 8'h00, 1'b0);
    op(2'b11, 16'h0600, 8'h00, 1'b0);
    rdc(16'h0700, 8'h55);
    op(2'b01, 16'h0700, 8'h00, 1'b1);
    rdc(16'h0700, 8'hFF);
    op(2'b00, 16'h06EF, 8'h3C, 1'b1);
    rdc(16'h06EF, 8'h3C);
    done("secured");
    // Crystal edges arrive about every five bus cycles, so ticks stretch
    xsel <= 1'b1;
    repeat (4) @(posedge mclk);
    op(2'b00, 16'h06E0, 8'h0F, 1'b1);
    span_chk("crystal tick span", 14, 30);
    rdc(16'h06E0, 8'h0F);
    done("crystal");
    final_report();
  end
endmodule
